//--- pkg/rbc_defs.svh
`ifndef RBC_DEFS_SVH
`define RBC_DEFS_SVH

// ---------------------------------------------------------------
// override pin positions on the data bus
// ---------------------------------------------------------------
`define RBC_BOOT_SELECT_BIT   18
`define RBC_PORT_WIDTH_BIT    19
`define RBC_STRENGTH_BIT      21
`define RBC_REFERENCE_BIT     22
`define RBC_PLL_SELECT_BIT    23
`define RBC_FLASH_ENABLE_BIT  28

// ---------------------------------------------------------------
// defaults used when the override pin is not asserted
// ---------------------------------------------------------------
`define RBC_DEF_BOOT_SELECT   1'h0
`define RBC_DEF_PORT_WIDTH    1'h1
`define RBC_DEF_STRENGTH      1'h0
`define RBC_DEF_PLL_SELECT    1'h1
`define RBC_DEF_REFERENCE     1'h1
`define RBC_DEF_FLASH_ENABLE  1'h1

// ---------------------------------------------------------------
// startup register values
// ---------------------------------------------------------------
`define RBC_RST_CS0_ENABLE    1'h0
`define RBC_RST_CS0_PORT_SIZE 1'h1
`define RBC_RST_CS1_ENABLE    1'h0
`define RBC_RST_STRENGTH      1'h0
`define RBC_RST_FLASH_ENABLE  1'h1

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define RBC_CLK_PERIOD_NS     20
`define RBC_OUT_CLK_PERIOD_NS 20
`define RBC_RELEASE_CYC ((`RBC_OUT_CLK_PERIOD_NS + `RBC_CLK_PERIOD_NS - 1) / `RBC_CLK_PERIOD_NS)
`define RBC_CNT_W             4

`endif

//--- pkg/rbc_pkg.sv
package rbc_pkg;

	typedef enum logic [1:0] {
		CLK_EXTERNAL,
		CLK_ONE_TO_ONE,
		CLK_NORMAL_EXT_REF,
		CLK_NORMAL_XTAL_REF
	} rbc_clk_mode_type;

	typedef enum logic [1:0] {
		SEQ_HOLD,
		SEQ_GUARD,
		SEQ_RUN
	} rbc_seq_state_type;

endpackage

//--- pkg/rbc_cfg_if.sv
`timescale 1ns/1ps

interface rbc_cfg_if import rbc_pkg::*; ();
	logic             override;
	logic             boot_select;
	logic             port_width;
	logic             pll_select;
	logic             reference;
	logic             supply;
	logic             emul;
	logic             cs0_enable;
	logic             cs0_port_size;
	logic             cs1_enable;
	rbc_clk_mode_type clk_mode;
	logic             synth_mode;
	logic             synth_select;
	logic             synth_reference;

	modport src (
		output override, boot_select, port_width, pll_select, reference, supply, emul,
		input  cs0_enable, cs0_port_size, cs1_enable, clk_mode,
		input  synth_mode, synth_select, synth_reference
	);

	modport dec (
		input  override, boot_select, port_width, pll_select, reference, supply, emul,
		output cs0_enable, cs0_port_size, cs1_enable, clk_mode,
		output synth_mode, synth_select, synth_reference
	);
endinterface

//--- design/rbc_sync2.sv
`timescale 1ns/1ps

module rbc_sync2 import rbc_pkg::*; #(
	parameter int W = 8
) (
	input  wire logic         clk_sys_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] stable_r;

	// no reset: the pins must keep being sampled while reset is held
	always_ff @(posedge clk_sys_in) begin
		meta_r   <= async_in;
		stable_r <= meta_r;
	end

	assign sync_out = stable_r;
endmodule

//--- design/rbc_decode.sv
`timescale 1ns/1ps
`include "rbc_defs.svh"

module rbc_decode import rbc_pkg::*; (
	rbc_cfg_if.dec cfg
);
	logic boot_sel;
	logic port_w;
	logic pll_sel;
	logic ref_sel;

	// ---------------------------------------------------------------
	// override levels or defaults
	// ---------------------------------------------------------------
	always_comb begin
		boot_sel = cfg.override ? cfg.boot_select : `RBC_DEF_BOOT_SELECT;
		port_w   = cfg.override ? cfg.port_width  : `RBC_DEF_PORT_WIDTH;
		pll_sel  = cfg.override ? cfg.pll_select  : `RBC_DEF_PLL_SELECT;
		ref_sel  = cfg.override ? cfg.reference   : `RBC_DEF_REFERENCE;
	end

	// ---------------------------------------------------------------
	// boot chip selects
	// ---------------------------------------------------------------
	always_comb begin
		cfg.cs0_enable    = boot_sel;
		cfg.cs0_port_size = boot_sel ? port_w : 1'h1;
		cfg.cs1_enable    = !boot_sel && cfg.emul;
	end

	// ---------------------------------------------------------------
	// clock mode
	// ---------------------------------------------------------------
	always_comb begin
		if (!cfg.supply) begin
			cfg.clk_mode = CLK_EXTERNAL;
		end else if (!pll_sel) begin
			cfg.clk_mode = CLK_ONE_TO_ONE;
		end else if (!ref_sel) begin
			cfg.clk_mode = CLK_NORMAL_EXT_REF;
		end else begin
			cfg.clk_mode = CLK_NORMAL_XTAL_REF;
		end
	end

	always_comb begin
		unique case (cfg.clk_mode)
			CLK_EXTERNAL: begin
				cfg.synth_mode      = 1'h0;
				cfg.synth_select    = 1'h0;
				cfg.synth_reference = 1'h0;
			end
			CLK_ONE_TO_ONE: begin
				cfg.synth_mode      = 1'h1;
				cfg.synth_select    = 1'h0;
				cfg.synth_reference = 1'h0;
			end
			CLK_NORMAL_EXT_REF: begin
				cfg.synth_mode      = 1'h1;
				cfg.synth_select    = 1'h1;
				cfg.synth_reference = 1'h0;
			end
			CLK_NORMAL_XTAL_REF: begin
				cfg.synth_mode      = 1'h1;
				cfg.synth_select    = 1'h1;
				cfg.synth_reference = 1'h1;
			end
		endcase
	end
endmodule

//--- design/rbc_top.sv
`timescale 1ns/1ps
`include "rbc_defs.svh"

// Functional notes
// - boot select disabled: enable clear, port size 32-bit, second select only if emulating
// - 16-bit boot port: enable set, port size clear, second select clear
// - 32-bit boot port: enable and port size set, second select clear
// - second select enable set only for emulation with internal boot
// - captured select bits stay after reset and software may overwrite them
// - boot line low: internal boot, 32-bit default, port width ignored
// - boot line high, width line low: external boot on 16-bit port
// - boot line high, width line high: external boot on 32-bit port
// - pin overrides apply only with config pin low during reset
// - strength line low gives default drive, high gives full drive
// - software may change drive strength after reset
// - three synthesizer status bits show clock mode and never change after reset
// - supply low: external clock mode, select and reference lines ignored
// - supply high, select high, reference low: normal mode, external reference
// - supply high, select and reference high: normal mode, crystal reference
// - flash line high enables internal flash, low disables it
// - reset loads startup values before the reset-time configuration
// - the block never raises an interrupt request
// - data pins stay inputs until one output clock after reset output negates
// - without config pin, defaults are used whatever the data pins show
module rbc_top import rbc_pkg::*; (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        reset_config_select_n_in,
	input  wire logic [31:0] data_pins_in,
	input  wire logic        synthesizer_supply_in,
	input  wire logic        emul_mode_in,
	input  wire logic        sw_select_wr_in,
	input  wire logic        sw_boot_enable_in,
	input  wire logic        sw_boot_port_size_in,
	input  wire logic        sw_emul_enable_in,
	input  wire logic        sw_strength_wr_in,
	input  wire logic        sw_strength_in,
	output logic             reset_output_out,
	output logic             data_pins_oe_out,
	output logic             config_valid_out,
	output logic             boot_select_enable_out,
	output logic             boot_port_size_out,
	output logic             emul_select_enable_out,
	output logic             pad_strength_out,
	output logic             synth_mode_out,
	output logic             synth_select_out,
	output logic             synth_reference_out,
	output logic             flash_enable_out
);
	// no interrupt request port exists on this block

	localparam logic [`RBC_CNT_W-1:0] RELEASE_LAST = `RBC_CNT_W'(`RBC_RELEASE_CYC - 1);

	rbc_seq_state_type     state_r;
	rbc_seq_state_type     state_nxt;
	logic [`RBC_CNT_W-1:0] guard_cnt_r;
	logic                  capture_w;
	logic                  reset_output_r;
	logic                  data_oe_r;
	logic                  valid_r;
	logic                  boot_en_r;
	logic                  boot_ps_r;
	logic                  emul_en_r;
	logic                  strength_r;
	logic                  syn_mode_r;
	logic                  syn_sel_r;
	logic                  syn_ref_r;
	logic                  flash_r;
	logic [7:0]            pins_sync;
	logic                  sy_boot;
	logic                  sy_width;
	logic                  sy_strength;
	logic                  sy_reference;
	logic                  sy_pll_select;
	logic                  sy_flash;
	logic                  sy_config_n;
	logic                  sy_supply;
	logic                  override_w;

	// ---------------------------------------------------------------
	// pin synchroniser
	// ---------------------------------------------------------------
	rbc_sync2 #(
		.W (8)
	) u_sync (
		.clk_sys_in (clk_sys_in),
		.async_in   ({data_pins_in[`RBC_BOOT_SELECT_BIT],
		              data_pins_in[`RBC_PORT_WIDTH_BIT],
		              data_pins_in[`RBC_STRENGTH_BIT],
		              data_pins_in[`RBC_REFERENCE_BIT],
		              data_pins_in[`RBC_PLL_SELECT_BIT],
		              data_pins_in[`RBC_FLASH_ENABLE_BIT],
		              reset_config_select_n_in,
		              synthesizer_supply_in}),
		.sync_out   (pins_sync)
	);

	assign sy_boot       = pins_sync[7];
	assign sy_width      = pins_sync[6];
	assign sy_strength   = pins_sync[5];
	assign sy_reference  = pins_sync[4];
	assign sy_pll_select = pins_sync[3];
	assign sy_flash      = pins_sync[2];
	assign sy_config_n   = pins_sync[1];
	assign sy_supply     = pins_sync[0];
	assign override_w    = !sy_config_n;

	// ---------------------------------------------------------------
	// configuration decode
	// ---------------------------------------------------------------
	rbc_cfg_if cfg ();

	assign cfg.override    = override_w;
	assign cfg.boot_select = sy_boot;
	assign cfg.port_width  = sy_width;
	assign cfg.pll_select  = sy_pll_select;
	assign cfg.reference   = sy_reference;
	assign cfg.supply      = sy_supply;
	assign cfg.emul        = emul_mode_in;

	rbc_decode u_decode (
		.cfg (cfg)
	);

	// ---------------------------------------------------------------
	// reset sequencer
	// ---------------------------------------------------------------
	// capture happens on the first edge after reset release, once only
	assign capture_w = (state_r == SEQ_HOLD) && !rst_in;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SEQ_HOLD: begin
				state_nxt = SEQ_GUARD;
			end
			SEQ_GUARD: begin
				if (guard_cnt_r == RELEASE_LAST) begin
					state_nxt = SEQ_RUN;
				end
			end
			SEQ_RUN: begin
				state_nxt = SEQ_RUN;
			end
			default: begin
				state_nxt = SEQ_HOLD;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_r <= SEQ_HOLD;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			guard_cnt_r <= '0;
		end else if (state_r == SEQ_GUARD) begin
			guard_cnt_r <= guard_cnt_r + `RBC_CNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			reset_output_r <= 1'h1;
		end else if (capture_w) begin
			reset_output_r <= 1'h0;
		end
	end

	// pins stay inputs for a full output clock so the override drivers can let go
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			data_oe_r <= 1'h0;
		end else if (state_r == SEQ_GUARD && state_nxt == SEQ_RUN) begin
			data_oe_r <= 1'h1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			valid_r <= 1'h0;
		end else if (capture_w) begin
			valid_r <= 1'h1;
		end
	end

	// ---------------------------------------------------------------
	// chip select control bits
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			boot_en_r <= `RBC_RST_CS0_ENABLE;
			boot_ps_r <= `RBC_RST_CS0_PORT_SIZE;
			emul_en_r <= `RBC_RST_CS1_ENABLE;
		end else if (capture_w) begin
			boot_en_r <= cfg.cs0_enable;
			boot_ps_r <= cfg.cs0_port_size;
			emul_en_r <= cfg.cs1_enable;
		end else if (sw_select_wr_in) begin
			boot_en_r <= sw_boot_enable_in;
			boot_ps_r <= sw_boot_port_size_in;
			emul_en_r <= sw_emul_enable_in;
		end
	end

	// ---------------------------------------------------------------
	// pad drive strength
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			strength_r <= `RBC_RST_STRENGTH;
		end else if (capture_w) begin
			strength_r <= override_w ? sy_strength : `RBC_DEF_STRENGTH;
		end else if (sw_strength_wr_in) begin
			strength_r <= sw_strength_in;
		end
	end

	// ---------------------------------------------------------------
	// synthesizer status, frozen once captured
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			syn_mode_r <= 1'h0;
			syn_sel_r  <= 1'h0;
			syn_ref_r  <= 1'h0;
		end else if (capture_w) begin
			syn_mode_r <= cfg.synth_mode;
			syn_sel_r  <= cfg.synth_select;
			syn_ref_r  <= cfg.synth_reference;
		end
	end

	// ---------------------------------------------------------------
	// internal flash enable
	// ---------------------------------------------------------------
	// an external boot with the flash line left high would clash at address zero
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			flash_r <= `RBC_RST_FLASH_ENABLE;
		end else if (capture_w) begin
			flash_r <= override_w ? sy_flash : `RBC_DEF_FLASH_ENABLE;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign reset_output_out       = reset_output_r;
	assign data_pins_oe_out       = data_oe_r;
	assign config_valid_out       = valid_r;
	assign boot_select_enable_out = boot_en_r;
	assign boot_port_size_out     = boot_ps_r;
	assign emul_select_enable_out = emul_en_r;
	assign pad_strength_out       = strength_r;
	assign synth_mode_out         = syn_mode_r;
	assign synth_select_out       = syn_sel_r;
	assign synth_reference_out    = syn_ref_r;
	assign flash_enable_out       = flash_r;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_boot_internal: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		capture_w && override_w && !sy_boot |=> !boot_en_r && boot_ps_r)
		else $error("internal boot did not leave select disabled at 32-bit");

	a_boot_ext_16: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		capture_w && override_w && sy_boot && !sy_width
		|=> boot_en_r && !boot_ps_r && !emul_en_r)
		else $error("16-bit external boot decoded wrongly");

	a_boot_ext_32: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		capture_w && override_w && sy_boot && sy_width
		|=> boot_en_r && boot_ps_r && !emul_en_r)
		else $error("32-bit external boot decoded wrongly");

	a_emul_select: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		capture_w |=> emul_en_r == $past(emul_mode_in && !(override_w && sy_boot)))
		else $error("second select enable does not follow emulation and boot");

	a_default_cfg: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		capture_w && !override_w |=> !boot_en_r && boot_ps_r
		&& strength_r == `RBC_DEF_STRENGTH && flash_r == `RBC_DEF_FLASH_ENABLE)
		else $error("defaults not applied without override");

	a_select_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		state_r == SEQ_RUN && sw_select_wr_in
		|=> {boot_en_r, boot_ps_r, emul_en_r}
		== $past({sw_boot_enable_in, sw_boot_port_size_in, sw_emul_enable_in}))
		else $error("software select write lost");

	a_strength_cfg: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		capture_w && override_w |=> strength_r == $past(sy_strength))
		else $error("drive strength not taken from strength line");

	a_strength_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		state_r == SEQ_RUN && sw_strength_wr_in |=> strength_r == $past(sw_strength_in))
		else $error("software strength write lost");

	a_synth_frozen: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		state_r != SEQ_HOLD |=> $stable({syn_mode_r, syn_sel_r, syn_ref_r}))
		else $error("synthesizer status changed after reset");

	a_supply_low: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		capture_w && !sy_supply |=> !syn_mode_r && !syn_sel_r && !syn_ref_r)
		else $error("supply low did not give external clock mode");

	a_pll_normal: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		capture_w && override_w && sy_supply && sy_pll_select
		|=> syn_mode_r && syn_sel_r && syn_ref_r == $past(sy_reference))
		else $error("normal pll mode reference wrong");

	a_pll_one_one: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		capture_w && override_w && sy_supply && !sy_pll_select
		|=> syn_mode_r && !syn_sel_r)
		else $error("one-to-one pll mode not selected");

	a_flash_cfg: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		capture_w && override_w |=> flash_r == $past(sy_flash) ##1 $stable(flash_r))
		else $error("flash enable not taken from flash line");

	a_pins_input: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		$fell(reset_output_r) |-> !data_oe_r ##1 data_oe_r)
		else $error("data pins released at the wrong time");
endmodule

//--- verification/rbc_override_model.sv
`timescale 1ns/1ps
`include "rbc_defs.svh"

module rbc_override_model (
	input  wire logic        clk_in,
	input  wire logic        reset_output_in,
	input  wire logic        slow_in,
	input  wire logic        boot_select_in,
	input  wire logic        port_width_in,
	input  wire logic        strength_in,
	input  wire logic        pll_select_in,
	input  wire logic        reference_in,
	input  wire logic        flash_enable_in,
	input  wire logic [31:0] noise_in,
	output logic      [31:0] data_pins_out
);
	logic        hold_r;
	logic [31:0] last_r;
	logic [31:0] pat;
	logic        drive;

	// ---------------------------------------------------------------
	// override levels
	// ---------------------------------------------------------------
	always_comb begin
		pat = noise_in;
		pat[`RBC_BOOT_SELECT_BIT] = boot_select_in;
		pat[`RBC_PORT_WIDTH_BIT] = port_width_in;
		pat[`RBC_STRENGTH_BIT] = strength_in;
		pat[`RBC_PLL_SELECT_BIT] = pll_select_in;
		pat[`RBC_REFERENCE_BIT] = reference_in;
		// external boot keeps internal flash away from address zero
		pat[`RBC_FLASH_ENABLE_BIT] = flash_enable_in & ~boot_select_in;
	end

	// ---------------------------------------------------------------
	// release
	// ---------------------------------------------------------------
	// slow mode lingers the full output clock that is allowed after reset output drops
	assign drive = reset_output_in | (slow_in & hold_r);
	always @(posedge clk_in) begin
		hold_r <= reset_output_in;
		last_r <= drive ? pat : ~last_r;
	end
	// a released bus has no keeper, so it shows a pattern flipping every cycle
	assign data_pins_out = drive ? pat : ~last_r;
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
`include "rbc_defs.svh"

module tb;
	logic        clk;
	logic        rst;
	logic        cfg_n;
	logic        supply;
	logic        emul;
	logic        sel_wr;
	logic        sw_en;
	logic        sw_ps;
	logic        sw_emul;
	logic        str_wr;
	logic        sw_str;
	logic        slow;
	logic        p_boot;
	logic        p_width;
	logic        p_str;
	logic        p_sel;
	logic        p_ref;
	logic        p_flash;
	logic [31:0] noise;
	logic [31:0] pins;
	logic        rst_out;
	logic        oe;
	logic        valid;
	logic        cs0en;
	logic        ps;
	logic        cs1en;
	logic        str;
	logic        s_mode;
	logic        s_sel;
	logic        s_ref;
	logic        flash;
	int          errors    = 0;
	int          cmp_count = 0;
	logic [31:0] seed      = 32'h0A44;

	rbc_top i_rbc_top (
		.clk_sys_in(clk), .rst_in(rst), .reset_config_select_n_in(cfg_n),
		.data_pins_in(pins), .synthesizer_supply_in(supply), .emul_mode_in(emul),
		.sw_select_wr_in(sel_wr), .sw_boot_enable_in(sw_en), .sw_boot_port_size_in(sw_ps),
		.sw_emul_enable_in(sw_emul), .sw_strength_wr_in(str_wr), .sw_strength_in(sw_str),
		.reset_output_out(rst_out), .data_pins_oe_out(oe), .config_valid_out(valid),
		.boot_select_enable_out(cs0en), .boot_port_size_out(ps),
		.emul_select_enable_out(cs1en), .pad_strength_out(str), .synth_mode_out(s_mode),
		.synth_select_out(s_sel), .synth_reference_out(s_ref), .flash_enable_out(flash)
	);

	rbc_override_model i_rbc_override_model (
		.clk_in(clk), .reset_output_in(rst_out), .slow_in(slow), .boot_select_in(p_boot),
		.port_width_in(p_width), .strength_in(p_str), .pll_select_in(p_sel),
		.reference_in(p_ref), .flash_enable_in(p_flash), .noise_in(noise),
		.data_pins_out(pins)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	function automatic logic [2:0] exp_sel(input logic b, input logic w, input logic e);
		return b ? {1'h1, w, 1'h0} : {1'h0, 1'h1, e};
	endfunction

	function automatic logic [2:0] exp_syn(input logic s, input logic p, input logic r);
		return s ? {1'h1, p, p & r} : 3'h0;
	endfunction

	task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// one reset, capture and software pass
	// ---------------------------------------------------------------
	task automatic run_one(input int idx);
		logic ovr, b, w, st, p, r, f, s, e;
		logic [3:0] wd;
		int k;
		seed = xs(seed);
		{e, s, f, r, p, st, w, b, ovr} = seed[8:0];
		// first 16 passes sweep every boot decode and the three supply-high clock decodes with the override taken
		if (idx < 16) begin
			ovr = 1'h1;
			s = 1'h1;
			b = idx[0];
			w = idx[1];
			p = idx[2];
			r = idx[3];
			e = idx[1];
		end
		@(negedge clk);
		rst = 1'h1;
		cfg_n = ~ovr;
		supply = s;
		emul = e;
		slow = seed[9];
		{p_boot, p_width, p_str, p_sel, p_ref, p_flash} = {b, w, st, p, r, f};
		noise = xs(seed);
		if (!ovr) begin
			{b, w, st} = {`RBC_DEF_BOOT_SELECT, `RBC_DEF_PORT_WIDTH, `RBC_DEF_STRENGTH};
			{p, r, f} = {`RBC_DEF_PLL_SELECT, `RBC_DEF_REFERENCE, `RBC_DEF_FLASH_ENABLE};
		end else
			f = f & ~b;
		repeat (10) @(negedge clk);
		check("reset state",
			{rst_out, oe, valid, cs0en, ps, cs1en, str, s_mode, s_sel, s_ref, flash},
			{3'h4, `RBC_RST_CS0_ENABLE, `RBC_RST_CS0_PORT_SIZE, `RBC_RST_CS1_ENABLE,
			`RBC_RST_STRENGTH, 3'h0, `RBC_RST_FLASH_ENABLE});
		rst = 1'h0;
		@(negedge clk);
		check("release", 11'({rst_out, valid, oe}), 11'h2);
		check("select bits", 11'({cs0en, ps, cs1en}),
			11'(exp_sel(b, w, e)));
		check("strength", 11'(str), 11'(st));
		check("synth", 11'({s_mode, s_sel, s_ref}), 11'(exp_syn(s, p, r)));
		check("flash", 11'(flash), 11'(f));
		cfg_n = ovr;
		supply = ~s;
		emul = ~e;
		@(negedge clk);
		check("pins oe", 11'(oe), 11'h1);
		for (k = 0; k < 2; k++) begin
			seed = xs(seed);
			wd = seed[3:0];
			sel_wr = 1'h1;
			str_wr = 1'h1;
			{sw_en, sw_ps, sw_emul, sw_str} = wd;
			@(negedge clk);
			check("sw select", 11'({cs0en, ps, cs1en}), 11'(wd[3:1]));
			check("sw strength", 11'(str), 11'(wd[0]));
		end
		sel_wr = 1'h0;
		str_wr = 1'h0;
		{sw_en, sw_ps, sw_emul, sw_str} = ~wd;
		repeat (3) @(negedge clk);
		check("held select", 11'({cs0en, ps, cs1en, str}), 11'(wd));
		check("synth held", 11'({s_mode, s_sel, s_ref}), 11'(exp_syn(s, p, r)));
		check("flash held", 11'(flash), 11'(f));
		$display("test %0d done", idx);
	endtask

	// ---------------------------------------------------------------
	// clock, watchdog, main sequence
	// ---------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// each pass takes 18 cycles; allow twice the whole run before calling it a hang
	initial begin
		repeat ((10 + 40 * 18) * 2) @(posedge clk);
		errors++;
		$display("[ERR] watchdog expected done seen hang");
		give_verdict();
	end

	initial begin
		{rst, cfg_n, supply, emul, sel_wr, sw_en, sw_ps, sw_emul} = 8'h80;
		{str_wr, sw_str, slow, p_boot, p_width, p_str, p_sel, p_ref, p_flash} = 9'h0;
		noise = 32'h0;
		repeat (10) @(negedge clk);
		for (int i = 0; i < 40; i++)
			run_one(i);
		give_verdict();
	end
endmodule
